// File: verilog/sdc_pkg.sv
// shared constants and types for the split direct-mapped cache controller
package sdc_pkg;

	localparam int ADDR_W     = 32;
	localparam int WORD_W     = 32;
	localparam int BE_W       = 4;
	localparam int TAG_LSB    = 12;
	localparam int TAG_W      = ADDR_W - TAG_LSB;
	localparam int IC_LINES   = 1024;
	localparam int IC_WORDS   = 4096;
	localparam int DC_WORDS   = 2048;
	localparam int IC_LINE_W  = 10;
	localparam int DC_IDX_W   = 11;
	localparam int WB_DEPTH   = 4;

	localparam logic [1:0]        LAST_WORD   = 2'h3;
	localparam logic [1:0]        FIRST_WORD  = 2'h0;
	localparam logic [3:0]        LINE_OFFSET = 4'h0;
	localparam logic [1:0]        BYTE_OFFSET = 2'h0;
	localparam logic [BE_W-1:0]   FULL_BE     = 4'hf;
	localparam logic [WORD_W-1:0] RST_WORD    = 32'h0000_0000;
	localparam logic [TAG_W-1:0]  RST_TAG     = 20'h0_0000;

	typedef enum logic [2:0] {
		I_IDLE   = 3'h0,
		I_LOOK   = 3'h1,
		I_REQ    = 3'h2,
		I_FILL   = 3'h3,
		I_SETTLE = 3'h4
	} sdc_istate_t;

	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_LOOK = 3'h1,
		D_REQ  = 3'h2,
		D_WAIT = 3'h3,
		D_ACK  = 3'h4
	} sdc_dstate_t;

	typedef struct packed {
		logic              req;
		logic              we;
		logic              cacheable;
		logic [BE_W-1:0]   be;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} sdc_dreq_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
		logic [BE_W-1:0]   be;
	} sdc_wb_t;

	localparam sdc_dreq_t RST_DREQ = '0;

endpackage

// File: verilog/sdc_ctrl.sv
// cache controller top with its posted write buffer
`timescale 1ns/10ps

module sdc_fifo #(
	parameter int WIDTH = 68,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  empty
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
	localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready  = (count != FULL_CNT);
	assign out_valid = (count != '0);
	assign empty     = (count == '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

module sdc_ctrl (
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      sys_rst,
	// configuration
	input  wire logic                      alt_size,
	input  wire logic                      flush,
	// instruction fetch port
	input  wire logic                      if_req,
	input  wire logic [31:0]               if_addr,
	output logic                           if_ack,
	output logic [31:0]                    if_data,
	// data port
	input  wire sdc_pkg::sdc_dreq_t        d_in,
	output logic                           d_ack,
	output logic [31:0]                    d_rdata,
	// memory read port
	output logic                           mr_req,
	output logic [31:0]                    mr_addr,
	output logic                           mr_quad,
	input  wire logic                      mr_gnt,
	input  wire logic                      mr_rvalid,
	input  wire logic [31:0]               mr_rdata,
	// memory write port
	output logic                           mw_valid,
	output sdc_pkg::sdc_wb_t               mw_entry,
	input  wire logic                      mw_ready
);
	import sdc_pkg::*;

	// size-dependent indexing
	// instruction line index for the current size setting
	function automatic logic [IC_LINE_W-1:0] i_line(input logic [ADDR_W-1:0] a, input logic alt);
		i_line = alt ? {1'b0, a[12:4]} : a[13:4];
	endfunction

	// data word index for the current size setting
	function automatic logic [DC_IDX_W-1:0] d_idx(input logic [ADDR_W-1:0] a, input logic alt);
		d_idx = alt ? a[12:2] : {1'b0, a[11:2]};
	endfunction

	sdc_istate_t         istate;
	logic [ADDR_W-1:0]   iaddr_q;
	logic [TAG_W-1:0]    itag_q;
	logic [WORD_W-1:0]   idata_q;
	logic [1:0]          ifill_cnt;
	logic [IC_LINES-1:0] ival;
	logic [TAG_W-1:0]    itag_mem [IC_LINES];
	logic [WORD_W-1:0]   idata_mem [IC_WORDS];
	logic                i_hit;
	logic                i_issue;
	logic                stream_hit;
	logic                ifill_last;

	sdc_dstate_t         dstate;
	sdc_dreq_t           dq;
	logic [TAG_W-1:0]    dtag_q;
	logic [WORD_W-1:0]   ddata_q;
	logic [DC_WORDS-1:0] dval;
	logic [TAG_W-1:0]    dtag_mem [DC_WORDS];
	logic [WORD_W-1:0]   ddata_mem [DC_WORDS];
	logic                d_hit;
	logic                d_full;
	logic                d_load_miss;
	logic                d_rd_pending;
	logic                d_issue;
	logic                dc_we;
	logic [WORD_W-1:0]   merged;

	sdc_wb_t             wb_in;
	logic                wb_push;
	logic                wb_in_ready;
	logic                wb_empty;

	// instruction lookup: stored tag against physical high bits, valid required
	// hit detection
	assign i_hit      = ival[i_line(iaddr_q, alt_size)] && (itag_q == iaddr_q[ADDR_W-1:TAG_LSB]);
	assign ifill_last = (istate == I_FILL) && mr_rvalid && (ifill_cnt == LAST_WORD);
	assign stream_hit = (istate == I_FILL) && mr_rvalid && if_req
		&& (if_addr[ADDR_W-1:2] == {iaddr_q[ADDR_W-1:4], ifill_cnt});

	assign d_rd_pending = (dstate == D_REQ) || (dstate == D_WAIT) || (dstate == D_LOOK && d_load_miss);
	assign d_issue      = (dstate == D_REQ) && wb_empty && (istate != I_FILL);
	assign i_issue      = (istate == I_REQ) && !d_rd_pending;

	assign mr_req  = d_issue || i_issue;
	assign mr_quad = !d_issue;
	assign mr_addr = d_issue ? {dq.addr[ADDR_W-1:2], BYTE_OFFSET} : {iaddr_q[ADDR_W-1:4], LINE_OFFSET};

	// sample physical address and read tag with data
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			iaddr_q <= '0;
			itag_q  <= RST_TAG;
			idata_q <= RST_WORD;
		end else if (istate == I_IDLE && if_req) begin
			iaddr_q <= if_addr;
			itag_q  <= itag_mem[i_line(if_addr, alt_size)];
			idata_q <= idata_mem[{i_line(if_addr, alt_size), if_addr[3:2]}];
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			istate <= I_IDLE;
		end else begin
			unique case (istate)
				I_IDLE:   if (if_req) istate <= I_LOOK;
				I_LOOK:   istate <= i_hit ? I_SETTLE : I_REQ;
				I_REQ:    if (i_issue && mr_gnt) istate <= I_FILL;
				I_FILL:   if (ifill_last) istate <= I_SETTLE;
				I_SETTLE: istate <= I_IDLE;
				default:  istate <= I_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (istate == I_REQ && i_issue && mr_gnt) begin
			itag_mem[i_line(iaddr_q, alt_size)] <= iaddr_q[ADDR_W-1:TAG_LSB];
		end
		if (istate == I_FILL && mr_rvalid) begin
			idata_mem[{i_line(iaddr_q, alt_size), ifill_cnt}] <= mr_rdata;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ifill_cnt <= FIRST_WORD;
		end else if (istate == I_REQ) begin
			ifill_cnt <= FIRST_WORD;
		end else if (istate == I_FILL && mr_rvalid) begin
			ifill_cnt <= ifill_cnt + 1'b1;
		end
	end

	// valid flags: refill completion wins over flush
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ival <= '0;
		end else begin
			if (flush) begin
				ival <= '0;
			end
			if (istate == I_REQ && i_issue && mr_gnt && !flush) begin
				ival[i_line(iaddr_q, alt_size)] <= 1'b0;
			end
			if (ifill_last) begin
				ival[i_line(iaddr_q, alt_size)] <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			if_ack  <= 1'b0;
			if_data <= RST_WORD;
		end else begin
			if_ack <= (istate == I_LOOK && i_hit) || stream_hit;
			if (istate == I_LOOK && i_hit) begin
				if_data <= idata_q;
			end else if (stream_hit) begin
				if_data <= mr_rdata;
			end
		end
	end

	assign d_hit       = dq.cacheable && dval[d_idx(dq.addr, alt_size)] && (dtag_q == dq.addr[ADDR_W-1:TAG_LSB]);
	assign d_full      = (dq.be == FULL_BE);
	assign d_load_miss = !dq.we && !d_hit;
	assign d_ack       = (dstate == D_ACK);

	for (genvar b = 0; b < BE_W; b++) begin : g_merge
		assign merged[8*b +: 8] = dq.be[b] ? dq.wdata[8*b +: 8] : ddata_q[8*b +: 8];
	end

	// store writes cache only for cacheable full stores or hits
	assign dc_we   = (dstate == D_LOOK) && dq.we && dq.cacheable && (d_full || d_hit) && wb_in_ready;
	// every store enters the write buffer
	assign wb_push = (dstate == D_LOOK) && dq.we;
	assign wb_in.addr = dq.addr;
	assign wb_in.data = d_hit ? merged : dq.wdata;
	assign wb_in.be   = d_hit ? FULL_BE : dq.be;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dq      <= RST_DREQ;
			dtag_q  <= RST_TAG;
			ddata_q <= RST_WORD;
		end else if (dstate == D_IDLE && d_in.req) begin
			dq      <= d_in;
			dtag_q  <= dtag_mem[d_idx(d_in.addr, alt_size)];
			ddata_q <= ddata_mem[d_idx(d_in.addr, alt_size)];
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dstate <= D_IDLE;
		end else begin
			unique case (dstate)
				D_IDLE: if (d_in.req) dstate <= D_LOOK;
				D_LOOK: begin
					if (dq.we) begin
						if (wb_in_ready) dstate <= D_ACK;
					end else begin
						dstate <= d_hit ? D_ACK : D_REQ;
					end
				end
				D_REQ:   if (d_issue && mr_gnt) dstate <= D_WAIT;
				D_WAIT:  if (mr_rvalid) dstate <= D_ACK;
				D_ACK:   dstate <= D_IDLE;
				default: dstate <= D_IDLE;
			endcase
		end
	end

	// single slot written by store or refill
	always_ff @(posedge core_clk) begin
		if (dc_we) begin
			dtag_mem[d_idx(dq.addr, alt_size)]  <= dq.addr[ADDR_W-1:TAG_LSB];
			ddata_mem[d_idx(dq.addr, alt_size)] <= merged;
		end else if (dstate == D_WAIT && mr_rvalid && dq.cacheable) begin
			dtag_mem[d_idx(dq.addr, alt_size)]  <= dq.addr[ADDR_W-1:TAG_LSB];
			ddata_mem[d_idx(dq.addr, alt_size)] <= mr_rdata;
		end
	end

	// data valid flags, set wins over flush
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dval <= '0;
		end else begin
			if (flush) begin
				dval <= '0;
			end
			if (dc_we || (dstate == D_WAIT && mr_rvalid && dq.cacheable)) begin
				dval[d_idx(dq.addr, alt_size)] <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			d_rdata <= RST_WORD;
		end else if (dstate == D_LOOK && !dq.we && d_hit) begin
			d_rdata <= ddata_q;
		end else if (dstate == D_WAIT && mr_rvalid) begin
			d_rdata <= mr_rdata;
		end
	end

	sdc_fifo #(
		.WIDTH ($bits(sdc_wb_t)),
		.DEPTH (WB_DEPTH)
	) u_wbuf (
		.clk       (core_clk),
		.rst       (sys_rst),
		.in_valid  (wb_push),
		.in_ready  (wb_in_ready),
		.in_data   (wb_in),
		.out_valid (mw_valid),
		.out_ready (mw_ready),
		.out_data  (mw_entry),
		.empty     (wb_empty)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	imiss_no_ack_a: assert property ((istate == I_LOOK && !i_hit) |=> !if_ack && istate == I_REQ)
		else $error("instruction miss acknowledged");
	dhit_data_a: assert property ((dstate == D_LOOK && !dq.we && d_hit) |=> d_ack && d_rdata == $past(ddata_q))
		else $error("data hit returned wrong word");
	uncached_skip_a: assert property ((dstate == D_LOOK && dq.we && !dq.cacheable) |-> !dc_we)
		else $error("uncacheable store wrote cache");
	store_post_a: assert property ((wb_push && wb_in_ready) |=> d_ack ##1 dstate == D_IDLE)
		else $error("store not posted in one cycle");
	merge_full_a: assert property ((wb_push && d_hit && !d_full) |-> wb_in.be == FULL_BE && wb_in.data == merged)
		else $error("partial hit not sent as full word");
	partial_miss_a: assert property ((dstate == D_LOOK && dq.we && !d_hit && !d_full) |-> !dc_we && wb_in.be == dq.be)
		else $error("partial miss touched cache");
	quad_read_a: assert property ((mr_req && !d_issue) |-> mr_quad && mr_addr[3:0] == LINE_OFFSET)
		else $error("instruction miss not a quad read");
	data_first_a: assert property ((istate == I_REQ && d_rd_pending) |-> !mr_req || !mr_quad)
		else $error("instruction read issued before data miss");
	fill_end_a: assert property ((istate == I_FILL && mr_rvalid && ifill_cnt == LAST_WORD) |=> istate == I_SETTLE ##1 istate == I_IDLE)
		else $error("refill did not finish after four words");
	write_through_a: assert property (dc_we |-> wb_push && wb_in_ready)
		else $error("cache store without memory write");

	hit_read_c: cover property (dstate == D_LOOK && !dq.we && d_hit);
	stream_c: cover property (stream_hit ##[1:8] stream_hit);
	partial_hit_c: cover property (wb_push && d_hit && !d_full);
	wb_full_c: cover property (wb_push && !wb_in_ready);
endmodule

// File: verification/sdc_mem_model.sv
// memory side model: read grants with word returns, write sink
`timescale 1ns/10ps
module sdc_mem_model (
	// clock
	input  wire logic             clk,
	// memory read port
	input  wire logic             mr_req,
	input  wire logic [31:0]      mr_addr,
	input  wire logic             mr_quad,
	output logic                  mr_gnt,
	output logic                  mr_rvalid,
	output logic [31:0]           mr_rdata,
	// memory write port
	input  wire logic             mw_valid,
	input  wire sdc_pkg::sdc_wb_t mw_entry,
	output logic                  mw_ready,
	// write stall and word gap
	input  wire logic             hold,
	input  wire logic [3:0]       lat
);
	import sdc_pkg::*;
	logic [31:0] mem [logic [31:0]];
	logic [31:0] a;
	logic [31:0] w;
	logic        q;

	function automatic logic [31:0] rdw(input logic [31:0] x);
		return mem.exists(x) ? mem[x] : {x[15:0], ~x[15:0]};
	endfunction

	assign mw_ready = ~hold;

	// accepted writes merge their byte lanes
	always @(posedge clk) begin
		if (mw_valid && mw_ready) begin
			w = rdw(mw_entry.addr);
			for (int b = 0; b < 4; b++) begin
				if (mw_entry.be[b]) w[8*b+:8] = mw_entry.data[8*b+:8];
			end
			mem[mw_entry.addr] = w;
		end
	end

	// grant while requested, taken only when request and grant meet at an edge;
	// then one or four words, released data shows inverted
	initial begin
		mr_gnt = 1'b0;
		mr_rvalid = 1'b0;
		mr_rdata = '1;
		forever begin
			@(posedge clk);
			if (mr_req && mr_gnt) begin
				a = mr_addr;
				q = mr_quad;
				#1 mr_gnt = 1'b0;
				for (int k = 0; k < (q ? 4 : 1); k++) begin
					repeat (lat) begin
						@(posedge clk);
						#1;
					end
					mr_rvalid = 1'b1;
					mr_rdata = rdw(a + 32'(4 * k));
					@(posedge clk);
					#1;
					if (lat != 4'h0 || k == (q ? 3 : 0)) begin
						mr_rvalid = 1'b0;
						mr_rdata = ~mr_rdata;
					end
				end
			end else begin
				#1 mr_gnt = mr_req;
			end
		end
	end
endmodule

// File: verification/sdc_ctrl_tb.sv
// self-checking bench for the split cache controller
`timescale 1ns/10ps
module sdc_ctrl_tb;
	import sdc_pkg::*;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        alt_size = 1'b0;
	logic        flush = 1'b0;
	logic        if_req = 1'b0;
	logic [31:0] if_addr = '0;
	sdc_dreq_t   d_in = RST_DREQ;
	logic        hold = 1'b0;
	logic [3:0]  lat = 4'h0;
	logic        if_ack, d_ack, mr_req, mr_quad, mr_gnt, mr_rvalid, mw_valid, mw_ready;
	logic [31:0] if_data, d_rdata, mr_addr, mr_rdata, rd;
	sdc_wb_t     mw_entry;
	sdc_wb_t     wq[$];
	logic [32:0] rq[$];
	int          num_errors = 0;
	int          checks_done = 0;
	int          nrv = 0;

	always #5 core_clk = ~core_clk;

	sdc_ctrl dut (.core_clk, .sys_rst, .alt_size, .flush, .if_req, .if_addr, .if_ack, .if_data, .d_in, .d_ack,
		.d_rdata, .mr_req, .mr_addr, .mr_quad, .mr_gnt, .mr_rvalid, .mr_rdata, .mw_valid, .mw_entry, .mw_ready);
	sdc_mem_model mem_i (.clk(core_clk), .mr_req, .mr_addr, .mr_quad, .mr_gnt, .mr_rvalid, .mr_rdata,
		.mw_valid, .mw_entry, .mw_ready, .hold, .lat);

	// log grants, returned words and drained writes
	always @(posedge core_clk) begin
		if (mr_req && mr_gnt) rq.push_back({mr_quad, mr_addr});
		if (mr_rvalid) nrv++;
		if (mw_valid && mw_ready) wq.push_back(mw_entry);
	end

	function automatic logic [31:0] mv(input logic [31:0] x);
		return {x[15:0], ~x[15:0]};
	endfunction

	task automatic chk(input string n, input logic [67:0] e, input logic [67:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wt(ref logic s);
		for (int i = 0; i < 300; i++) begin
			@(posedge core_clk);
			#1;
			if (s === 1'b1) return;
		end
		chk("handshake", 1, 0);
		finish_test();
	endtask

	task automatic wn(input int n);
		for (int i = 0; i < 300 && wq.size() < n; i++) @(posedge core_clk);
		#1 chk("write count", n, wq.size());
	endtask

	task automatic fetch(input logic [31:0] a);
		@(posedge core_clk);
		#1 if_req = 1'b1;
		if_addr = a;
		wt(if_ack);
		rd = if_data;
		@(posedge core_clk);
		#1 if_req = 1'b0;
		if_addr = ~a;
	endtask

	task automatic dput(input logic we, c, input logic [3:0] be, input logic [31:0] a, w);
		@(posedge core_clk);
		#1 d_in = '{1'b1, we, c, be, a, w};
	endtask

	task automatic dget;
		wt(d_ack);
		rd = d_rdata;
		@(posedge core_clk);
		#1 d_in = '{1'b0, ~d_in.we, ~d_in.cacheable, ~d_in.be, ~d_in.addr, ~d_in.wdata};
	endtask

	task automatic dx(input logic we, c, input logic [3:0] be, input logic [31:0] a, w);
		dput(we, c, be, a, w);
		dget();
	endtask

	task automatic t_ifetch;
		int n = rq.size();
		lat = 4'h2;
		nrv = 0;
		fetch(32'h1000_0104);
		chk("stream", 1, nrv < 4);
		chk("fetch data", mv(32'h1000_0104), rd);
		chk("block read", {1'b1, 32'h1000_0100}, rq[n]);
		fetch(32'h1000_010c);
		chk("word3", mv(32'h1000_010c), rd);
		fetch(32'h1000_0100);
		chk("word0", mv(32'h1000_0100), rd);
		chk("one line read", n + 1, rq.size());
		fetch(32'h1000_4100);
		fetch(32'h1000_0100);
		chk("slot evicts", n + 3, rq.size());
		lat = 4'h0;
		$display("test ifetch finished");
	endtask

	task automatic t_dat;
		int n = rq.size();
		wq.delete();
		dx(0, 1, FULL_BE, '0, '0);
		chk("reset miss", {1'b0, 32'h0}, rq[n]);
		chk("load data", mv('0), rd);
		dx(0, 1, FULL_BE, '0, '0);
		chk("load hit", n + 1, rq.size());
		fetch('0);
		chk("split caches", {1'b1, 32'h0}, rq[n + 1]);
		dx(1, 1, FULL_BE, 32'h2000_0008, 32'h1111_2222);
		wn(1);
		chk("through", {32'h2000_0008, 32'h1111_2222, FULL_BE}, wq[0]);
		dx(1, 0, FULL_BE, 32'h2000_0008, 32'h3333_4444);
		wn(2);
		chk("uncached", {32'h2000_0008, 32'h3333_4444, FULL_BE}, wq[1]);
		dx(0, 1, FULL_BE, 32'h2000_0008, '0);
		chk("cache kept", 32'h1111_2222, rd);
		chk("allocated", n + 2, rq.size());
		dx(1, 1, 4'h2, 32'h2000_0008, 32'haaaa_bbbb);
		wn(3);
		chk("merged write", {32'h2000_0008, 32'h1111_bb22, FULL_BE}, wq[2]);
		dx(0, 1, FULL_BE, 32'h2000_0008, '0);
		chk("merged cache", 32'h1111_bb22, rd);
		dx(1, 1, 4'h1, 32'h2000_0010, 32'h0000_00cc);
		wn(4);
		chk("partial miss", {32'h2000_0010, 32'h0000_00cc, 4'h1}, wq[3]);
		dx(0, 1, FULL_BE, 32'h2000_0010, '0);
		chk("no allocate", n + 3, rq.size());
		chk("memory merged", 32'h0010_ffcc, rd);
		$display("test data finished");
	endtask

	task automatic t_wbuf;
		logic s = 1'b0;
		hold = 1'b1;
		wq.delete();
		for (int i = 0; i < 4; i++) dx(1, 0, FULL_BE, 32'h2000_0100 + 32'(4 * i), 32'(i));
		dput(1, 0, FULL_BE, 32'h2000_0110, 32'h4);
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			#1 s = s | d_ack;
		end
		chk("full stalls", 0, s);
		hold = 1'b0;
		dget();
		wn(5);
		for (int i = 0; i < 5; i++) chk("order", {32'h2000_0100 + 32'(4 * i), 32'(i), FULL_BE}, wq[i]);
		$display("test write buffer finished");
	endtask

	task automatic t_both;
		int n = rq.size();
		lat = 4'h1;
		@(posedge core_clk);
		#1 if_req = 1'b1;
		if_addr = 32'h3000_0200;
		d_in = '{1'b1, 1'b0, 1'b1, FULL_BE, 32'h3000_0400, 32'h0};
		dget();
		chk("load first", mv(32'h3000_0400), rd);
		wt(if_ack);
		chk("fetch next", mv(32'h3000_0200), if_data);
		@(posedge core_clk);
		#1 if_req = 1'b0;
		chk("data read", {1'b0, 32'h3000_0400}, rq[n]);
		chk("then block", {1'b1, 32'h3000_0200}, rq[n + 1]);
		lat = 4'h0;
		$display("test simultaneous misses finished");
	endtask

	task automatic t_size;
		int n;
		for (int m = 0; m < 2; m++) begin
			n = rq.size();
			dx(0, 1, FULL_BE, 32'h4000_0020, '0);
			dx(0, 1, FULL_BE, 32'h4000_1020, '0);
			dx(0, 1, FULL_BE, 32'h4000_0020, '0);
			chk("size reads", n + 3 - m, rq.size());
			alt_size = 1'b1;
			flush = 1'b1;
			@(posedge core_clk);
			#1 flush = 1'b0;
		end
		n = rq.size();
		dx(0, 1, FULL_BE, 32'h4000_1020, '0);
		chk("flushed", n + 1, rq.size());
		$display("test size finished");
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		t_ifetch();
		t_dat();
		t_wbuf();
		t_both();
		t_size();
		finish_test();
	end
endmodule
